//--- shared/led_drv_pkg.sv
// Package: constants for the serial shift/latch LED driver.
// Assumes a single 20 MHz system clock; no software registers.
package led_drv_pkg;
    localparam int STAGE_COUNT = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_NS = 50;
    localparam int FIFO_RESET_COUNT = 0;
endpackage : led_drv_pkg

//--- verilog/event_fifo.sv
// Holds a small FIFO of words, flip-flop storage addressed by index.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module event_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_r != DEPTH[AW:0]);
    assign out_valid_out = (cnt_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_r];

    // Storage
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    // Pointers and fill level
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : event_fifo
`default_nettype wire

//--- verilog/led_shift_latch.sv
// Holds the 16-stage serial shift register with parallel LED latch.
// Assumes shift_clk, latch_clk, shift_in, wipe_n and out_gate_n arrive
// as pins from a host and are sampled on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module led_shift_latch
    import led_drv_pkg::*;
#(
    parameter int STAGES = STAGE_COUNT,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // Host pins
    input wire logic shift_clk_in,
    input wire logic latch_clk_in,
    input wire logic shift_in,
    input wire logic wipe_n_in,
    input wire logic out_gate_n_in,
    // Cascade output
    output logic chain_out,
    // LED outputs, drive value and enable
    output logic [STAGES-1:0] led_drive_out,
    output logic [STAGES-1:0] led_drive_oe_out,
    // Edge events dropped while the queue was full
    output logic overflow_out
);
    // Two-flop synchronisers, bits: shift clk, latch clk, data, wipe_n, gate_n
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic shift_clk_d_r;
    logic latch_clk_d_r;
    logic shift_rise;
    logic latch_rise;
    logic wipe_n;
    logic gate_n;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_r <= 5'h18;
            sync2_r <= 5'h18;
        end else begin
            sync1_r <= {out_gate_n_in, wipe_n_in, shift_in,
                        latch_clk_in, shift_clk_in};
            sync2_r <= sync1_r;
        end
    end

    assign wipe_n = sync2_r[3];
    assign gate_n = sync2_r[4];

    // Edge detection on the synchronised clocks
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_clk_d_r <= 1'b0;
            latch_clk_d_r <= 1'b0;
        end else begin
            shift_clk_d_r <= sync2_r[0];
            latch_clk_d_r <= sync2_r[1];
        end
    end

    assign shift_rise = sync2_r[0] && !shift_clk_d_r;
    assign latch_rise = sync2_r[1] && !latch_clk_d_r;

    // Event queue: {latch, shift, data}; tied edges stay in one entry
    logic ev_valid;
    logic ev_ready;
    logic [2:0] ev_data;
    logic q_valid;
    logic [2:0] q_data;
    logic q_ready;

    assign ev_valid = (shift_rise || latch_rise) && wipe_n;
    assign ev_data = {latch_rise, shift_rise, sync2_r[2]};
    // Always draining; entries popped during wipe are dropped, not replayed
    assign q_ready = 1'b1;

    event_fifo #(
        .WIDTH(3),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(ev_valid),
        .in_ready_out(ev_ready),
        .in_data_in(ev_data),
        .out_valid_out(q_valid),
        .out_ready_in(q_ready),
        .out_data_out(q_data)
    );

    logic do_shift;
    logic do_latch;
    assign do_shift = q_valid && wipe_n && q_data[1];
    assign do_latch = q_valid && wipe_n && q_data[2];

    // Overflow flag, sticky until wipe
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            overflow_out <= 1'b0;
        end else if (ev_valid && !ev_ready) begin
            overflow_out <= 1'b1;
        end else if (!wipe_n) begin
            overflow_out <= 1'b0;
        end
    end

    // Shift stages
    logic [STAGES-1:0] shift_r;
    logic [STAGES-1:0] latch_r;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_r <= SHIFT_RESET[STAGES-1:0];
        end else if (!wipe_n) begin
            shift_r <= SHIFT_RESET[STAGES-1:0];
        end else if (do_shift) begin
            shift_r <= {shift_r[STAGES-2:0],
                        q_data[0]};
        end
    end

    // Holding latch; takes the pre-shift state when both edges coincide
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            latch_r <= LATCH_RESET[STAGES-1:0];
        end else if (!wipe_n) begin
            latch_r <= LATCH_RESET[STAGES-1:0];
        end else if (do_latch) begin
            latch_r <= shift_r;
        end
    end

    assign chain_out = shift_r[STAGES-1];

    // Open-drain style outputs: drive high only when latched high
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_led
            assign led_drive_out[g] = latch_r[g];
            assign led_drive_oe_out[g] = latch_r[g] && !gate_n
                && wipe_n;
        end
    endgenerate

    chk_wipe_clears: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        !wipe_n |=> (shift_r == '0) && (latch_r == '0) && !chain_out)
        else $error("wipe did not clear stages");

    chk_wipe_drains: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        !wipe_n |=> !q_valid)
        else $error("queued edge kept through wipe");

    chk_gate_floats: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        gate_n |-> (led_drive_oe_out == '0))
        else $error("outputs driven while gated");

    chk_shift_moves: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (do_shift && wipe_n) |=> !wipe_n || (shift_r[STAGES-1:1] ==
            $past(shift_r[STAGES-2:0]) && shift_r[0] == $past(q_data[0])))
        else $error("shift did not move stages");

    chk_latch_copies: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (do_latch && wipe_n) |=> !wipe_n || (latch_r == $past(shift_r)))
        else $error("latch did not copy stages");

    chk_latch_holds: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (!do_latch && wipe_n) |=> !wipe_n || $stable(latch_r))
        else $error("latch changed without edge");

    chk_shift_holds: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (!do_shift && wipe_n) |=> !wipe_n || $stable(shift_r))
        else $error("stages changed without shift");

    chk_shift_pulse: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        shift_rise |=> !shift_rise)
        else $error("shift edge seen twice");

    chk_latch_pulse: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        latch_rise |=> !latch_rise)
        else $error("latch edge seen twice");

    chk_chain_tail: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        chain_out == shift_r[STAGES-1])
        else $error("chain output not last stage");

    chk_low_floats: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (led_drive_oe_out & ~latch_r) == '0)
        else $error("low bit driven");

    chk_oe_tracks: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (!gate_n && wipe_n) |-> (led_drive_oe_out == latch_r))
        else $error("latched high not driven");

    chk_edge_queued: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (shift_rise && latch_rise && wipe_n && ev_ready) |=> q_valid)
        else $error("tied edge lost");

    chk_tied_one_entry: assert property (
        @(posedge mclk_in) disable iff (!arst_n_in)
        (shift_rise && latch_rise && wipe_n && ev_ready)
            |=> (q_data[2:1] == 2'b11))
        else $error("tied edges split");
endmodule : led_shift_latch
`default_nettype wire

//--- sim/host_model.sv
// Host model: drives the serial pins of the LED shift/latch block.
// Assumes mclk_in at 20 MHz; pins change 5 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic mclk_in,
    // Pins toward the device
    output logic shift_clk_out,
    output logic latch_clk_out,
    output logic data_out,
    output logic wipe_n_out,
    output logic gate_n_out
);
    initial begin
        shift_clk_out = 1'b0;
        latch_clk_out = 1'b0;
        data_out = 1'b0;
        wipe_n_out = 1'b1;
        gate_n_out = 1'b1;
    end
    // Data set up, clocks raised and held, data then turned over
    task automatic pulse(input logic s, input logic l, input logic d);
        @(posedge mclk_in) #5 data_out = d;
        repeat (3) @(posedge mclk_in);
        #5 shift_clk_out = s;
        latch_clk_out = l;
        repeat (3) @(posedge mclk_in);
        #5 shift_clk_out = 1'b0;
        latch_clk_out = 1'b0;
        repeat (3) @(posedge mclk_in);
        #5 data_out = ~d;
        repeat (3) @(posedge mclk_in);
    endtask : pulse
    task automatic set_gate(input logic g);
        @(posedge mclk_in) #5 gate_n_out = g;
    endtask : set_gate
    task automatic wipe();
        @(posedge mclk_in) #5 wipe_n_out = 1'b0;
        repeat (6) @(posedge mclk_in);
        #5 wipe_n_out = 1'b1;
        repeat (6) @(posedge mclk_in);
    endtask : wipe
endmodule : host_model
`default_nettype wire

//--- sim/testbench.sv
// Testbench: random frames, tied clocks, gating and wipe checks.
// Assumes host_model owns the serial pins, the testbench drives clock and reset; expectations come from local models.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import led_drv_pkg::*;
    logic mclk_in, arst_n_in, shift_clk, latch_clk, sdata, wipe_n, gate_n;
    logic chain_out, overflow_out;
    logic [15:0] led_drive_out, led_drive_oe_out, sh, la, w;
    int num_errors = 0, samples_checked = 0, seed = 33;
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    host_model u_host (.mclk_in(mclk_in), .shift_clk_out(shift_clk),
        .latch_clk_out(latch_clk), .data_out(sdata),
        .wipe_n_out(wipe_n), .gate_n_out(gate_n));
    led_shift_latch u_led_shift_latch (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .shift_clk_in(shift_clk),
        .latch_clk_in(latch_clk), .shift_in(sdata), .wipe_n_in(wipe_n),
        .out_gate_n_in(gate_n), .chain_out(chain_out),
        .led_drive_out(led_drive_out), .led_drive_oe_out(led_drive_oe_out),
        .overflow_out(overflow_out));
    function automatic logic [15:0] oe_expect(logic [15:0] l, logic g);
        return g ? 16'h0000 : l;
    endfunction : oe_expect
    task automatic check();
        @(negedge mclk_in);
        `CHK(chain_out, sh[15])
        `CHK(led_drive_out, la)
        `CHK(led_drive_oe_out, oe_expect(la, gate_n))
        `CHK(overflow_out, 1'b0)
    endtask : check
    task automatic step(input logic s, input logic l, input logic d);
        if (l) la = sh;
        if (s) sh = {sh[14:0], d};
        u_host.pulse(s, l, d);
        check();
    endtask : step
    task automatic frame(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            if (i == 7) u_host.set_gate(1'($random(seed)));
            step(1'b1, 1'b0, v[i]);
        end
        step(1'b0, 1'b1, 1'b0);
        `CHK(led_drive_out, v)
    endtask : frame
    task automatic summarize();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (60000) @(posedge mclk_in);
        num_errors++;
        summarize();
    end
    initial begin
        arst_n_in = 1'b0;
        sh = SHIFT_RESET;
        la = LATCH_RESET;
        repeat (4) @(posedge mclk_in);
        #5 arst_n_in = 1'b1;
        repeat (4) @(posedge mclk_in);
        check();
        u_host.set_gate(1'b0);
        frame(16'hFFFF);
        frame(16'h8001);
        frame(16'h0000);
        for (int k = 0; k < 10; k++) begin
            w = 16'($random(seed));
            frame(w);
        end
        u_host.set_gate(1'b0);
        for (int k = 0; k < 6; k++) begin
            step(1'b1, 1'b1, 1'($random(seed)));
        end
        for (int k = 0; k < 8; k++) step(1'b1, 1'b0, 1'b1);
        u_host.set_gate(1'b1);
        repeat (3) @(posedge mclk_in);
        check();
        u_host.set_gate(1'b0);
        u_host.wipe();
        sh = 16'h0000;
        la = 16'h0000;
        check();
        frame(16'hA5C3);
        summarize();
    end
endmodule : testbench
`default_nettype wire
